// File: tb/ccd_clean_sequencer_properties.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ccd_clean_checker #(
    parameter int          ROW_CYCLES = 4,
    parameter logic [31:0] MAX_DECAY  = 32'h00FF_FFFF
) (
    input wire logic        clk,          // Clock
    input wire logic        rst,          // Reset
    input wire logic [3:0]  addr,         // Index
    input wire logic [31:0] wdata,        // Write data
    input wire logic        wr,           // Write
    input wire logic        rd,           // Read
    input wire logic [31:0] rdata,        // Read data
    input wire logic        ext_trigger,  // Trigger
    input wire logic        read_out,     // Exposure low
    input wire logic        shift_row,    // Row pulse
    input wire logic        dump_charge,  // Discard
    input wire logic        serial_clean, // Serial clean
    input wire logic        busy          // Acquiring
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ro_no_dump_a: assert property (!read_out |-> !dump_charge)
        else $error("discard active during exposure");
    ro_busy_a: assert property (!read_out |-> busy)
        else $error("exposure outside acquisition");
    expose_quiet_a: assert property (!read_out |-> !shift_row && !serial_clean)
        else $error("shift during exposure");
    flush_ctx_a: assert property (serial_clean |-> busy && read_out && !dump_charge)
        else $error("serial clean out of readout");
    serial_pulse_a: assert property (serial_clean |=> !serial_clean)
        else $error("serial clean too long");
    row_gap_a: assert property (shift_row |=> !shift_row [*3])
        else $error("row shifts too close");
    clean_resume_a: assert property ($fell(busy) |-> ##[0:4] dump_charge)
        else $error("cleaning not resumed");
    frame_no_clean_a: assert property (busy && !dump_charge |=> !dump_charge || !busy)
        else $error("clean inside acquisition");

    // Main scenarios reached
    cover property ($fell(read_out));
    cover property (serial_clean);
    cover property ($fell(busy));
endmodule

bind ccd_clean_sequencer ccd_clean_checker #(.ROW_CYCLES(ROW_CYCLES), .MAX_DECAY(MAX_DECAY))
    i_checker (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_trigger(ext_trigger), .read_out(read_out), .shift_row(shift_row),
    .dump_charge(dump_charge), .serial_clean(serial_clean), .busy(busy));

`default_nettype wire

// File: tb/test_ccd_clean_sequencer.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module test_ccd_clean_sequencer;
    logic        clk, rst, wr, rd, fire, ext_trigger;
    logic        read_out, shift_row, dump_charge, serial_clean, busy;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, got;
    int          bad_count, n_checks;

    // Small decay clamp keeps the long delay affordable
    ccd_clean_sequencer #(.ROW_CYCLES(4), .MAX_DECAY(32'h0000_0190)) i_dut (.clk(clk),
        .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ext_trigger(ext_trigger), .read_out(read_out), .shift_row(shift_row),
        .dump_charge(dump_charge), .serial_clean(serial_clean), .busy(busy));
    trig_source i_trig (.clk(clk), .rst(rst), .fire(fire), .ext_trigger(ext_trigger));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_reg(clean_seq_pkg::REG_CLEANS, got);
        check(got, 32'h0000_0001);
        rd_reg(clean_seq_pkg::REG_ROWS, got);
        check(got, 32'h0000_0002);
        rd_reg(4'h8, got);
        check(got, 32'h0000_0000);
        check(32'(dump_charge), 32'h0000_0000);
        wr_reg(clean_seq_pkg::REG_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clk);
        rd_reg(clean_seq_pkg::REG_STATUS, got);
        check(got & 32'h0000_0007, 32'h0000_0001);
        check(32'(dump_charge), 32'h0000_0001);
    endtask
    // Counts are taken cycle by cycle, since the outputs are pulses
    task automatic acquire(input logic [15:0] ex, input logic [15:0] rw, input logic sf,
                           input logic [31:0] dk, input int dec, input logic [15:0] fr);
        int pre, fin, rows_rd, dumps, sers, lows, gap, n, dcy;
        wr_reg(clean_seq_pkg::REG_CLEANS, {16'h0, ex});
        wr_reg(clean_seq_pkg::REG_ROWS, {16'h0, rw});
        wr_reg(clean_seq_pkg::REG_DARKROWS, dk);
        wr_reg(clean_seq_pkg::REG_DECAY, 32'(dec));
        // Frame count in the upper half, exposure cycles in the lower
        wr_reg(clean_seq_pkg::REG_EXPOSE, {fr, 16'h0020});
        wr_reg(clean_seq_pkg::REG_CTRL, {27'h0, sf, 3'h0, 1'b1});
        repeat (40) @(posedge clk);
        wr_reg(clean_seq_pkg::REG_CTRL, {27'h0, sf, 3'h1, 1'b1});
        {pre, fin, rows_rd, dumps, sers, gap, n} = '0;
        dcy = (dec * 250 > 400) ? 400 : dec * 250;
        while (read_out !== 1'b0 && n < 2000) begin
            @(posedge clk);
            #1 n++;
            if (shift_row === 1'b1 && busy === 1'b1) pre++;
            if (shift_row === 1'b1 && busy !== 1'b1) fin++;
        end
        check(32'(n < 2000), 32'h1);
        // Held settings must ignore this change; driven on the edge like any write
        fork
            begin
                @(posedge clk);
                wr_reg(clean_seq_pkg::REG_DECAY, 32'h0);
            end
        join_none
        lows = 1;
        n = 0;
        while (busy === 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
            if (read_out === 1'b0) lows++;
            if (read_out === 1'b1 && rows_rd == 0 && sers == 0) gap++;
            if (shift_row === 1'b1) rows_rd++;
            if (serial_clean === 1'b1) sers++;
            if (dump_charge === 1'b1) dumps++;
        end
        check(32'(n < 3000), 32'h1);
        // Back onto the edge, so the next write is launched there
        @(posedge clk);
        check(32'(pre), 32'(ex) * 32'(rw));
        check(32'(fin <= rw), 32'h1);
        check(32'(lows), 32'(fr) * 32'h20);
        check(32'(rows_rd), 32'(fr) * (dk + 32'h1));
        check(32'(sers), 32'(fr) * 32'(sf && dk == 0));
        check(32'(dumps), 32'h0);
        check(32'(gap >= dcy), 32'h1);
    endtask
    task automatic t_trigger();
        int n;
        wr_reg(clean_seq_pkg::REG_CTRL, 32'h0000_0001);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        n = 0;
        repeat (60) @(posedge clk) if (busy === 1'b1 || read_out === 1'b0) n++;
        check(32'(n), 32'h0);
        wr_reg(clean_seq_pkg::REG_CTRL, 32'h0000_000D);
        repeat (20) @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        n = 0;
        while (read_out !== 1'b0 && n < 200) @(posedge clk) n++;
        check(32'(read_out), 32'h0);
        while (busy === 1'b1 && n < 2000) @(posedge clk) n++;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Free-running clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        #(30000 * 4);
        bad_count++;
        results();
    end
    initial begin
        {rst, wr, rd, fire, addr, wdata, bad_count, n_checks} = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        acquire(16'h0, 16'h1, 1'b0, 32'h2, 1, 16'h1);
        acquire(16'h2, 16'h3, 1'b1, 32'h0, 1, 16'h2);
        acquire(16'h1, 16'h2, 1'b1, 32'h1, 3000, 16'h1);
        t_trigger();
        results();
    end
endmodule

`default_nettype wire

// File: tb/trig_source.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module trig_source (
    input  wire logic clk,        // Bench clock
    input  wire logic rst,        // Async reset
    input  wire logic fire,       // Request one trigger
    output logic      ext_trigger // Trigger level to sequencer
);
    logic [3:0] hold;

    // Level held eight cycles so the edge cannot be missed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold <= 4'h0;
        end else if (fire) begin
            hold <= 4'h8;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end
    end

    // Low between requests, never left floating
    assign ext_trigger = (hold != 4'h0);
endmodule

`default_nettype wire

// File: verilog/ccd_clean_sequencer.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [RULE1] While idle awaiting start, clean cycles repeat, each shifting and discarding rows.
// [RULE2] Cleaning begins once the clean pattern is marked programmed, no request needed.
// [RULE3] A start request leads to one final clean, then exposure.
// [RULE4] Multi-frame: clean only before first exposure and after last readout.
// [RULE5] A start arriving mid-clean waits until that clean fully completes.
// [RULE6] Extra clean count adds that many full cleans before exposure; zero adds none.
// [RULE7] Extra cleans follow the start request after the running clean ends.
// [RULE8] Each clean shifts exactly rows_per_flush rows.
// [RULE9] Clean-until-trigger applies only with external sync selected.
// [RULE10] Nonzero leading dark rows flush the serial register before active rows.
// [RULE11] Zero dark rows with flush option forces a serial clean before readout.
// [RULE12] Readout-status output goes low at exposure start, after all cleans.
// [RULE13] A programmable decay delay separates exposure end and readout start.
// [RULE14] Host programs 3 ms decay for very short exposures on affected sensors.
// [RULE15] Settings are latched at acquisition start and held for the sequence; here only cleans, rows, decay and serial flush are held.
module ccd_clean_sequencer #(
    parameter int          ROW_CYCLES = 4,        // Clock cycles per row shift
    parameter logic [31:0] MAX_DECAY  = 32'h00FF_FFFF
) (
    input  wire logic        clk,          // 250 MHz clock
    input  wire logic        rst,          // Async reset, active high
    input  wire logic [3:0]  addr,         // Register index
    input  wire logic [31:0] wdata,        // Write data
    input  wire logic        wr,           // Write strobe
    input  wire logic        rd,           // Read strobe
    output logic      [31:0] rdata,        // Read data, cycle after rd
    input  wire logic        ext_trigger,  // External start trigger, level
    output logic             read_out,     // Low while exposing
    output logic             shift_row,    // Parallel row shift pulse
    output logic             dump_charge,  // Charge discarded, not digitised
    output logic             serial_clean, // Serial register clean pulse
    output logic             busy          // Acquisition in progress
);

    ////////////////////////////////////////////////////////////////////////////////
    // Host settings

    logic                       programmed;
    logic                       ext_sync;
    logic                       cont_clean;
    logic                       start_req;
    clean_seq_pkg::settings_t   cfg;
    clean_seq_pkg::settings_t   held;
    logic [15:0]                frames;
    logic [31:0]                expose_time;
    logic [15:0]                read_rows;
    logic [15:0]                dark_rows;
    clean_seq_pkg::state_t      state;
    logic [15:0]                row_cnt;
    logic [31:0]                tick;
    logic [15:0]                clean_cnt;
    logic [15:0]                frame_cnt;
    logic                       trig_d;
    logic                       start_ev;
    logic                       clean_done;

    // Decay in microseconds to cycles; clamped so a huge setting cannot stall readout
    function automatic logic [31:0] us_to_cycles(input logic [31:0] us);
        logic [63:0] p;
        p = 64'(us) * 64'(clean_seq_pkg::CLK_MHZ);
        return (p > 64'(MAX_DECAY)) ? MAX_DECAY : p[31:0];
    endfunction

    // Clean and extra clean share one decode: rows shifted there are discarded
    function automatic logic is_cleaning(input clean_seq_pkg::state_t s);
        return (s == clean_seq_pkg::ST_CLEAN) || (s == clean_seq_pkg::ST_EXTRA);
    endfunction

    // Register writes; start request is a pending flag consumed by the sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            programmed  <= 1'b0;
            ext_sync    <= 1'b0;
            cont_clean  <= 1'b0;
            cfg.cleans  <= clean_seq_pkg::CLEANS_RESET;
            cfg.rows    <= clean_seq_pkg::ROWS_RESET;
            cfg.decay   <= clean_seq_pkg::DECAY_RESET;
            cfg.ser_flush <= 1'b0;
            frames      <= clean_seq_pkg::FRAMES_RESET;
            expose_time <= clean_seq_pkg::EXPOSE_RESET;
            read_rows   <= clean_seq_pkg::READROWS_RESET;
            dark_rows   <= clean_seq_pkg::DARKROWS_RESET;
        end else if (wr) begin
            if (addr == clean_seq_pkg::REG_CTRL) begin
                programmed    <= wdata[clean_seq_pkg::CTRL_PROGRAMMED];
                ext_sync      <= wdata[clean_seq_pkg::CTRL_EXT_SYNC];
                cont_clean    <= wdata[clean_seq_pkg::CTRL_CONT_CLEAN];
                cfg.ser_flush <= wdata[clean_seq_pkg::CTRL_SER_FLUSH];
            end else if (addr == clean_seq_pkg::REG_CLEANS) begin
                cfg.cleans <= wdata[15:0];
            end else if (addr == clean_seq_pkg::REG_ROWS) begin
                cfg.rows <= (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0];
            end else if (addr == clean_seq_pkg::REG_DECAY) begin
                cfg.decay <= wdata;
            end else if (addr == clean_seq_pkg::REG_EXPOSE) begin
                // Upper half is the frame count, so exposure keeps the lower half only
                expose_time <= {16'h0000, (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0]};
                frames      <= (wdata[31:16] == 16'h0000) ? 16'h0001 : wdata[31:16];
            end else if (addr == clean_seq_pkg::REG_READROWS) begin
                read_rows <= (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0];
            end else if (addr == clean_seq_pkg::REG_DARKROWS) begin
                dark_rows <= wdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Start events

    // Trigger edge only counts when continuous clean under external sync
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_d <= 1'b0;
        end else begin
            trig_d <= ext_trigger;
        end
    end

    assign start_ev = (wr && addr == clean_seq_pkg::REG_CTRL && wdata[clean_seq_pkg::CTRL_START])
                    || (ext_sync && cont_clean && ext_trigger && !trig_d); // [RULE9]

    // Pending start; a new request beats the consume in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_req <= 1'b0;
        end else if (start_ev) begin
            start_req <= 1'b1;
        end else if (state == clean_seq_pkg::ST_CLEAN && clean_done) begin
            start_req <= 1'b0;
        end
    end

    // Last slot of the last row of a clean
    assign clean_done = (row_cnt == held.rows - 16'h0001) && (tick == 32'(ROW_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Row and time counters, frame and extra clean bookkeeping
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= clean_seq_pkg::ST_IDLE;
            row_cnt   <= 16'h0000;
            tick      <= 32'h0000_0000;
            clean_cnt <= 16'h0000;
            frame_cnt <= 16'h0000;
            held      <= '0;
        end else begin
            case (state)
                clean_seq_pkg::ST_IDLE: begin
                    held <= cfg;
                    if (programmed) begin // [RULE2]
                        state   <= clean_seq_pkg::ST_CLEAN;
                        row_cnt <= 16'h0000;
                        tick    <= 32'h0000_0000;
                    end
                end
                clean_seq_pkg::ST_CLEAN, clean_seq_pkg::ST_EXTRA: begin
                    if (tick == 32'(ROW_CYCLES - 1)) begin
                        tick <= 32'h0000_0000;
                        if (row_cnt == held.rows - 16'h0001) begin // [RULE8]
                            row_cnt <= 16'h0000;
                            if (state == clean_seq_pkg::ST_CLEAN) begin
                                // Start only acts at a clean boundary: latency up to one clean
                                if (start_req) begin // [RULE5] [RULE3]
                                    clean_cnt <= held.cleans;
                                    frame_cnt <= frames;
                                    state <= (held.cleans == 16'h0000) ? // [RULE6] [RULE7]
                                        clean_seq_pkg::ST_EXPOSE : clean_seq_pkg::ST_EXTRA;
                                end else if (!programmed) begin
                                    state <= clean_seq_pkg::ST_IDLE;
                                end else begin
                                    held <= cfg; // [RULE15]
                                end // [RULE1]
                            end else if (clean_cnt == 16'h0001) begin
                                clean_cnt <= 16'h0000;
                                state     <= clean_seq_pkg::ST_EXPOSE;
                            end else begin
                                clean_cnt <= clean_cnt - 16'h0001; // [RULE6]
                            end
                        end else begin
                            row_cnt <= row_cnt + 16'h0001;
                        end
                    end else begin
                        tick <= tick + 32'h0000_0001;
                    end
                end
                clean_seq_pkg::ST_EXPOSE: begin
                    // Exposure length counted in clock cycles
                    if (tick >= expose_time - 32'h0000_0001) begin
                        tick  <= 32'h0000_0000;
                        state <= clean_seq_pkg::ST_DECAY;
                    end else begin
                        tick <= tick + 32'h0000_0001;
                    end
                end
                clean_seq_pkg::ST_DECAY: begin
                    // Held copies of decay and serial flush, so a host rewrite of those mid-sequence changes nothing
                    if (tick >= us_to_cycles(held.decay)) begin // [RULE13]
                        tick    <= 32'h0000_0000;
                        row_cnt <= 16'h0000;
                        if (dark_rows == 16'h0000 && held.ser_flush) begin // [RULE11]
                            state <= clean_seq_pkg::ST_SERIAL;
                        end else begin
                            state <= clean_seq_pkg::ST_READ; // [RULE10]
                        end
                    end else begin
                        tick <= tick + 32'h0000_0001;
                    end
                end
                clean_seq_pkg::ST_SERIAL: begin
                    // One row slot for the forced serial register clean
                    if (tick == 32'(ROW_CYCLES - 1)) begin
                        tick  <= 32'h0000_0000;
                        state <= clean_seq_pkg::ST_READ;
                    end else begin
                        tick <= tick + 32'h0000_0001;
                    end
                end
                clean_seq_pkg::ST_READ: begin
                    // Dark rows lead, shifted through the serial register first
                    if (tick == 32'(ROW_CYCLES - 1)) begin
                        tick <= 32'h0000_0000;
                        if (row_cnt == dark_rows + read_rows - 16'h0001) begin
                            row_cnt <= 16'h0000;
                            if (frame_cnt == 16'h0001) begin // [RULE4]
                                frame_cnt <= 16'h0000;
                                held      <= cfg;
                                state     <= clean_seq_pkg::ST_IDLE;
                            end else begin
                                frame_cnt <= frame_cnt - 16'h0001;
                                state     <= clean_seq_pkg::ST_EXPOSE;
                            end
                        end else begin
                            row_cnt <= row_cnt + 16'h0001;
                        end
                    end else begin
                        tick <= tick + 32'h0000_0001;
                    end
                end
                default: begin
                    state <= clean_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    // One shift pulse per row, at the start of its slot
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_out     <= 1'b1;
            shift_row    <= 1'b0;
            dump_charge  <= 1'b0;
            serial_clean <= 1'b0;
            busy         <= 1'b0;
        end else begin
            read_out     <= (state != clean_seq_pkg::ST_EXPOSE); // [RULE12]
            shift_row    <= (tick == 32'h0000_0000)
                            && (is_cleaning(state) || state == clean_seq_pkg::ST_READ);
            dump_charge  <= is_cleaning(state); // [RULE1]
            serial_clean <= (state == clean_seq_pkg::ST_SERIAL) && (tick == 32'h0000_0000);
            busy         <= !(state == clean_seq_pkg::ST_IDLE || state == clean_seq_pkg::ST_CLEAN);
        end
    end

    // Read data, valid only in the cycle after rd
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            if (addr == clean_seq_pkg::REG_CTRL) begin
                rdata <= {27'h0, cfg.ser_flush, cont_clean, ext_sync, start_req, programmed};
            end else if (addr == clean_seq_pkg::REG_CLEANS) begin
                rdata <= {16'h0000, cfg.cleans};
            end else if (addr == clean_seq_pkg::REG_ROWS) begin
                rdata <= {16'h0000, cfg.rows};
            end else if (addr == clean_seq_pkg::REG_DECAY) begin
                rdata <= cfg.decay;
            end else if (addr == clean_seq_pkg::REG_EXPOSE) begin
                rdata <= {frames, expose_time[15:0]};
            end else if (addr == clean_seq_pkg::REG_READROWS) begin
                rdata <= {16'h0000, read_rows};
            end else if (addr == clean_seq_pkg::REG_DARKROWS) begin
                rdata <= {16'h0000, dark_rows};
            end else if (addr == clean_seq_pkg::REG_STATUS) begin
                rdata <= {frame_cnt, clean_cnt[11:0], 1'b0, state};
            end else begin
                rdata <= 32'h0000_0000;
            end
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire

// File: verilog/clean_seq_pkg.sv
package clean_seq_pkg;

    // Register indices on the plain port (byte address = 4 * index)
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_CLEANS   = 4'h1;
    localparam logic [3:0] REG_ROWS     = 4'h2;
    localparam logic [3:0] REG_DECAY    = 4'h3;
    localparam logic [3:0] REG_EXPOSE   = 4'h4;
    localparam logic [3:0] REG_READROWS = 4'h5;
    localparam logic [3:0] REG_DARKROWS = 4'h6;
    localparam logic [3:0] REG_STATUS   = 4'h7;

    // Control bit positions
    localparam int CTRL_PROGRAMMED = 0;
    localparam int CTRL_START      = 1;
    localparam int CTRL_EXT_SYNC   = 2;
    localparam int CTRL_CONT_CLEAN = 3;
    localparam int CTRL_SER_FLUSH  = 4;

    // Values after reset
    localparam logic [15:0] CLEANS_RESET = 16'h0001;
    localparam logic [15:0] ROWS_RESET   = 16'h0002;
    localparam logic [31:0] DECAY_RESET  = 32'h0000_0000;
    localparam logic [15:0] FRAMES_RESET = 16'h0001;
    localparam logic [31:0] EXPOSE_RESET   = 32'h0000_0001;
    localparam logic [15:0] READROWS_RESET = 16'h0001;
    localparam logic [15:0] DARKROWS_RESET = 16'h0000;

    // Clock rate, used to turn decay time in microseconds into cycles
    localparam int CLK_MHZ = 250;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CLEAN  = 3'b001,
        ST_EXTRA  = 3'b010,
        ST_EXPOSE = 3'b011,
        ST_DECAY  = 3'b100,
        ST_SERIAL = 3'b101,
        ST_READ   = 3'b110
    } state_t;

    typedef struct packed {
        logic [15:0] cleans;
        logic [15:0] rows;
        logic [31:0] decay;
        logic        ser_flush;
    } settings_t;

    typedef struct packed {
        logic        shift_row;
        logic        serial_clean;
        logic        read_row;
    } drive_t;

endpackage
